// ---- core/cfg_cmd_pkg.sv ----
// constants for the configuration command/status word
package cfg_cmd_pkg;
    localparam logic [7:0] CSC_OFFSET = 8'h04;
    localparam logic [31:0] CSC_RESET = 32'h02800000;
    localparam int BIT_PERR_DET = 31;
    localparam int BIT_SERR_SIG = 30;
    localparam int BIT_MABORT_RX = 29;
    localparam int BIT_TABORT_RX = 28;
    localparam int BIT_TABORT_SIG = 27;
    localparam int BIT_MDPERR = 24;
    localparam int BIT_FB2B_EN = 9;
    localparam int BIT_SERR_EN = 8;
    localparam int BIT_PERR_EN = 6;
    localparam int BIT_BM_EN = 2;
    localparam int BIT_MEM_EN = 1;
    // read-only fields: select timing 01, fast back-to-back capable, 33 MHz only
    localparam logic [1:0] SEL_TIMING_MEDIUM = 2'h1;
    localparam logic FB2B_CAPABLE = 1'h1;
    localparam logic CLK66_CAPABLE = 1'h0;
    localparam int SEL_TIMING_LO = 25;
    localparam int CAP_FB2B_BIT = 23;
    localparam int CAP_CLK_BIT = 16;
    localparam logic [31:0] W1C_MASK = 32'h19000000 | 32'he0000000;
    localparam logic [31:0] RW_MASK = 32'h00000346;
endpackage

// ---- core/w1c_flag.sv ----
// one sticky error flag, set by hardware, cleared by writing one
`timescale 1ns/1ps
module w1c_flag
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // set and clear
    input wire logic set_evt,
    input wire logic clr_wr,
    // state
    output logic flag_q
);
    logic flag_d;
    // set wins over a simultaneous clear
    assign flag_d = set_evt ? 1'b1 : (clr_wr ? 1'b0 : flag_q);
    always_ff @(posedge core_clk)
    begin
        if (rst)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end
endmodule

// ---- core/pci_config_status_command.sv ----
// configuration command/status word of the pci target and master
// How it works
// - the word answers configuration offset 04h, read/write, resetting to 0280_0000h.
// - each upper error flag clears when written with one unless its own event arrives in the same cycle, and holds when written with zero.
// - bit 31 sets whenever a parity error is detected.
// - bit 30 sets whenever the device signals a system error.
// - bit 29 sets when an own master cycle ends in master abort.
// - bit 28 sets when a target aborts an own master cycle.
// - bit 27 sets when the device itself ends a cycle with target abort.
// - bit 24 sets when the device as master sees a data parity error.
// - bits 26-25 read 01, medium select timing, and ignore writes.
// - bit 23 reads one, fast back-to-back capable as target.
// - bit 16 reads zero, only a 33 MHz clock is supported.
// - bit 6 enables the parity error response.
// - bit 2 allows the device to act as bus master.
// - bit 1 gates the claiming of memory cycles.
`timescale 1ns/1ps
module pci_config_status_command
    import cfg_cmd_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // configuration access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    // events from the pci logic
    input wire logic parity_err_evt,
    input wire logic sys_err_evt,
    input wire logic master_abort_evt,
    input wire logic target_abort_rx_evt,
    input wire logic target_abort_sig_evt,
    input wire logic master_data_perr_evt,
    // decode request from target logic
    input wire logic mem_hit,
    input wire logic master_req,
    // steering outputs
    output logic mem_claim,
    output logic master_start,
    output logic parity_response_enable,
    output logic sys_err_report_enable,
    output logic fast_b2b_enable,
    output logic bus_master_enable,
    output logic mem_space_enable
);
    ////////////////////////////////////////////////////////////////
    logic [31:0] ctl_q;
    logic [31:0] ctl_d;
    logic [31:0] rdata_d;
    logic [31:0] wmask;
    logic [31:0] word;
    logic [5:0] flags;
    logic [5:0] evts;
    logic [5:0] clrs;
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rsvd_view;

    // positions with neither storage nor a fixed code
    localparam logic [31:0] RO_MASK = (32'h00000003 << SEL_TIMING_LO) | (32'h00000001 << CAP_FB2B_BIT)
        | (32'h00000001 << CAP_CLK_BIT);
    localparam logic [31:0] RSVD_MASK = ~(W1C_MASK | RW_MASK | RO_MASK);

    assign hit = cfg_addr == CSC_OFFSET;
    assign wr_hit = cfg_wr && hit;
    assign rd_hit = cfg_rd && hit;
    assign wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
    assign evts = {parity_err_evt, sys_err_evt, master_abort_evt,
                   target_abort_rx_evt, target_abort_sig_evt, master_data_perr_evt};
    assign clrs = {cfg_wdata[BIT_PERR_DET] & cfg_be[3], cfg_wdata[BIT_SERR_SIG] & cfg_be[3],
                   cfg_wdata[BIT_MABORT_RX] & cfg_be[3], cfg_wdata[BIT_TABORT_RX] & cfg_be[3],
                   cfg_wdata[BIT_TABORT_SIG] & cfg_be[3], cfg_wdata[BIT_MDPERR] & cfg_be[3]};

    ////////////////////////////////////////////////////////////////
    // one flag per error event
    genvar g;
    generate
        for (g = 0; g < $bits(evts); g++)
        begin : g_flag
            w1c_flag u_flag
            (
                .core_clk(core_clk),
                .rst(rst),
                .set_evt(evts[g]),
                .clr_wr(wr_hit && clrs[g]),
                .flag_q(flags[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // writable enables, only masked positions stored
    assign ctl_d = wr_hit ? ((ctl_q & ~(wmask & RW_MASK)) | (cfg_wdata & wmask & RW_MASK)) : ctl_q;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            ctl_q <= CSC_RESET & RW_MASK;
        else
            ctl_q <= ctl_d;
    end

    assign parity_response_enable = ctl_q[BIT_PERR_EN];
    assign sys_err_report_enable = ctl_q[BIT_SERR_EN];
    assign fast_b2b_enable = ctl_q[BIT_FB2B_EN];
    assign bus_master_enable = ctl_q[BIT_BM_EN];
    assign mem_space_enable = ctl_q[BIT_MEM_EN];
    assign master_start = master_req && ctl_q[BIT_BM_EN];
    assign mem_claim = mem_hit && ctl_q[BIT_MEM_EN];

    ////////////////////////////////////////////////////////////////
    // read view
    always_comb
    begin
        word = ctl_q & RW_MASK;
        word[BIT_PERR_DET] = flags[5];
        word[BIT_SERR_SIG] = flags[4];
        word[BIT_MABORT_RX] = flags[3];
        word[BIT_TABORT_RX] = flags[2];
        word[BIT_TABORT_SIG] = flags[1];
        word[BIT_MDPERR] = flags[0];
        word[SEL_TIMING_LO +: 2] = SEL_TIMING_MEDIUM;
        word[CAP_FB2B_BIT] = FB2B_CAPABLE;
        word[CAP_CLK_BIT] = CLK66_CAPABLE;
    end

    assign rdata_d = rd_hit ? word : 32'h00000000;
    assign rsvd_view = word & RSVD_MASK;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            cfg_rdata <= 32'h00000000;
        else
            cfg_rdata <= rdata_d;
    end

    ////////////////////////////////////////////////////////////////
    // reset view
    AST_RESET_VALUE: assert property (@(posedge core_clk) $fell(rst) |-> word == CSC_RESET)
        else $error("word not at reset value after reset");

    AST_RESET_ENABLES: assert property (@(posedge core_clk) rst |=> ctl_q == 32'h00000000)
        else $error("enables not cleared by reset");

    AST_RESET_FLAGS: assert property (@(posedge core_clk) rst |=> flags == 6'h00)
        else $error("flags not cleared by reset");

    AST_RESET_RDATA: assert property (@(posedge core_clk) rst |=> cfg_rdata == 32'h00000000)
        else $error("read data not cleared by reset");

    // flags set by events
    AST_PERR_SET: assert property (@(posedge core_clk) disable iff (rst)
        parity_err_evt |=> word[BIT_PERR_DET])
        else $error("parity flag not set");

    AST_SERR_SET: assert property (@(posedge core_clk) disable iff (rst)
        sys_err_evt |=> word[BIT_SERR_SIG])
        else $error("system error flag not set");

    AST_MABORT_SET: assert property (@(posedge core_clk) disable iff (rst)
        master_abort_evt |=> word[BIT_MABORT_RX])
        else $error("master abort flag not set");

    AST_TABORT_RX_SET: assert property (@(posedge core_clk) disable iff (rst)
        target_abort_rx_evt |=> word[BIT_TABORT_RX])
        else $error("received target abort flag not set");

    AST_TABORT_SIG_SET: assert property (@(posedge core_clk) disable iff (rst)
        target_abort_sig_evt |=> word[BIT_TABORT_SIG])
        else $error("signalled target abort flag not set");

    AST_MASTER_PERR_SET: assert property (@(posedge core_clk) disable iff (rst)
        master_data_perr_evt |=> word[BIT_MDPERR])
        else $error("master parity flag not set");

    // write one clears, write zero holds
    AST_W1C_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && cfg_be[3] && cfg_wdata[BIT_PERR_DET] && !parity_err_evt |=> !flags[5])
        else $error("parity flag not cleared by write one");

    AST_SERR_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && cfg_be[3] && cfg_wdata[BIT_SERR_SIG] && !sys_err_evt |=> !flags[4])
        else $error("system error flag not cleared by write one");

    AST_MABORT_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && cfg_be[3] && cfg_wdata[BIT_MABORT_RX] && !master_abort_evt |=> !flags[3])
        else $error("master abort flag not cleared by write one");

    AST_TABORT_RX_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && cfg_be[3] && cfg_wdata[BIT_TABORT_RX] && !target_abort_rx_evt |=> !flags[2])
        else $error("received target abort flag not cleared by write one");

    AST_TABORT_SIG_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && cfg_be[3] && cfg_wdata[BIT_TABORT_SIG] && !target_abort_sig_evt |=> !flags[1])
        else $error("signalled target abort flag not cleared by write one");

    AST_MASTER_PERR_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && cfg_be[3] && cfg_wdata[BIT_MDPERR] && !master_data_perr_evt |=> !flags[0])
        else $error("master parity flag not cleared by write one");

    AST_W0_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && !cfg_wdata[BIT_SERR_SIG] && flags[4] |=> flags[4])
        else $error("flag lost on write zero");

    AST_PERR_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !parity_err_evt && !(wr_hit && cfg_be[3] && cfg_wdata[BIT_PERR_DET]) |=> $stable(flags[5]))
        else $error("parity flag changed without cause");

    AST_SERR_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !sys_err_evt && !(wr_hit && cfg_be[3] && cfg_wdata[BIT_SERR_SIG]) |=> $stable(flags[4]))
        else $error("system error flag changed without cause");

    AST_MABORT_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !master_abort_evt && !(wr_hit && cfg_be[3] && cfg_wdata[BIT_MABORT_RX]) |=> $stable(flags[3]))
        else $error("master abort flag changed without cause");

    AST_TABORT_RX_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !target_abort_rx_evt && !(wr_hit && cfg_be[3] && cfg_wdata[BIT_TABORT_RX]) |=> $stable(flags[2]))
        else $error("received target abort flag changed without cause");

    AST_TABORT_SIG_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !target_abort_sig_evt && !(wr_hit && cfg_be[3] && cfg_wdata[BIT_TABORT_SIG]) |=> $stable(flags[1]))
        else $error("signalled target abort flag changed without cause");

    AST_MASTER_PERR_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !master_data_perr_evt && !(wr_hit && cfg_be[3] && cfg_wdata[BIT_MDPERR]) |=> $stable(flags[0]))
        else $error("master parity flag changed without cause");

    // writable enables
    AST_PERR_EN_WR: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && cfg_be[0] |=> parity_response_enable == $past(cfg_wdata[BIT_PERR_EN]))
        else $error("parity enable not written");

    AST_LOW_EN_WR: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && cfg_be[0] |=> {bus_master_enable, mem_space_enable} ==
        $past({cfg_wdata[BIT_BM_EN], cfg_wdata[BIT_MEM_EN]}))
        else $error("master or memory enable not written");

    AST_EN_WR: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && cfg_be[1] |=> {fast_b2b_enable, sys_err_report_enable} ==
        $past({cfg_wdata[BIT_FB2B_EN], cfg_wdata[BIT_SERR_EN]}))
        else $error("enable bits not written");

    AST_LANE0_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && !cfg_be[0] |=> $stable({parity_response_enable, bus_master_enable, mem_space_enable}))
        else $error("low lane enables changed without byte enable");

    AST_LANE1_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        wr_hit && !cfg_be[1] |=> $stable({fast_b2b_enable, sys_err_report_enable}))
        else $error("high lane enables changed without byte enable");

    AST_MISS_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !wr_hit |=> $stable(ctl_q))
        else $error("enables changed without a write hit");

    AST_ENABLE_VIEW: assert property (@(posedge core_clk) disable iff (rst)
        {word[BIT_FB2B_EN], word[BIT_SERR_EN], word[BIT_PERR_EN], word[BIT_BM_EN], word[BIT_MEM_EN]} ==
        {fast_b2b_enable, sys_err_report_enable, parity_response_enable, bus_master_enable, mem_space_enable})
        else $error("enable outputs differ from read view");

    // memory and master gating
    AST_NO_MASTER: assert property (@(posedge core_clk) disable iff (rst)
        !bus_master_enable |-> !master_start)
        else $error("master start while disabled");

    AST_MASTER_GATE: assert property (@(posedge core_clk) disable iff (rst)
        master_start == (master_req && bus_master_enable))
        else $error("master start not gated");

    AST_MEM_GATE: assert property (@(posedge core_clk) disable iff (rst)
        mem_claim == (mem_hit && mem_space_enable))
        else $error("memory claim not gated");

    // read path
    AST_RDATA_HIT: assert property (@(posedge core_clk) disable iff (rst)
        rd_hit |=> cfg_rdata == $past(word))
        else $error("read data differ from the word");

    AST_RDATA_MISS: assert property (@(posedge core_clk) disable iff (rst)
        !rd_hit |=> cfg_rdata == 32'h00000000)
        else $error("read data not zero without a read hit");

    AST_RDATA_RO: assert property (@(posedge core_clk) disable iff (rst)
        rd_hit |=> cfg_rdata[SEL_TIMING_LO +: 2] == SEL_TIMING_MEDIUM
        && cfg_rdata[CAP_FB2B_BIT] == FB2B_CAPABLE && cfg_rdata[CAP_CLK_BIT] == CLK66_CAPABLE)
        else $error("read-only fields wrong in read data");

    AST_RO_FIELDS: assert property (@(posedge core_clk) disable iff (rst)
        word[SEL_TIMING_LO +: 2] == SEL_TIMING_MEDIUM
        && word[CAP_FB2B_BIT] == FB2B_CAPABLE && word[CAP_CLK_BIT] == CLK66_CAPABLE)
        else $error("read-only capability fields wrong");

    AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        rsvd_view == 32'h00000000)
        else $error("reserved bits not zero");

    AST_RSVD_RDATA: assert property (@(posedge core_clk) disable iff (rst)
        (cfg_rdata & RSVD_MASK) == 32'h00000000)
        else $error("reserved bits not zero in read data");
endmodule

// ---- bench/cfg_host.sv ----
// host bridge model issuing configuration cycles
`timescale 1ns/1ps
module cfg_host
(
    // clock
    input wire logic core_clk,
    // configuration cycle
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata
);
    initial {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
    // one write or read; read data stand for one cycle after the taking edge
    task automatic cyc(input logic w, input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        {cfg_wr, cfg_rd} <= {w, !w};
        cfg_addr <= a;
        cfg_be <= b;
        cfg_wdata <= d;
        @(posedge core_clk);
        {cfg_wr, cfg_rd} <= 2'h0;
        // released lines show the inverse, never the old value
        cfg_addr <= ~a;
        cfg_be <= ~b;
        cfg_wdata <= ~d;
        #1 q = cfg_rdata;
    endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the command/status word
`timescale 1ns/1ps
module tb_top
    import cfg_cmd_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_wr, cfg_rd;
    logic [7:0] cfg_addr, a;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, q, m, exp_word;
    logic [5:0] evt = 6'h0;
    logic [5:0] coll_evt;
    logic mem_hit = 1'b0;
    logic master_req = 1'b0;
    logic mem_claim, master_start, en_par, en_serr, en_fast, en_bm, en_mem;
    int mismatches = 0;
    int tests_run = 0;
    always #10 core_clk = ~core_clk;
    cfg_host cfg_host_inst (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
    pci_config_status_command pci_config_status_command_inst (.core_clk(core_clk), .rst(rst),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .parity_err_evt(evt[5]), .sys_err_evt(evt[4]), .master_abort_evt(evt[3]),
        .target_abort_rx_evt(evt[2]), .target_abort_sig_evt(evt[1]), .master_data_perr_evt(evt[0]),
        .mem_hit(mem_hit), .master_req(master_req), .mem_claim(mem_claim), .master_start(master_start),
        .parity_response_enable(en_par), .sys_err_report_enable(en_serr), .fast_b2b_enable(en_fast),
        .bus_master_enable(en_bm), .mem_space_enable(en_mem));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] wa, input logic [3:0] b, input logic [31:0] d);
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        cfg_host_inst.cyc(1'b1, wa, b, d, q);
        if (wa == 8'h04)
            exp_word = (exp_word & ~(d & m & W1C_MASK) & ~(m & RW_MASK)) | (d & m & RW_MASK);
    endtask
    task automatic rd_chk(input logic [7:0] ra);
        cfg_host_inst.cyc(1'b0, ra, 4'hf, $urandom, q);
        chk("word", (ra == 8'h04) ? exp_word : 32'h0, q);
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge core_clk);
        evt <= v;
        @(posedge core_clk);
        evt <= 6'h0;
        exp_word = exp_word | {v[5:1], 2'h0, v[0], 24'h0};
    endtask
    task automatic test_done;
        $display("tests %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h5f6b));
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        exp_word = 32'h02800000;
        rd_chk(8'h04);
        rd_chk(8'h08);
        $display("test reset done");
        repeat (40)
        begin
            @(posedge core_clk);
            mem_hit <= 1'($urandom);
            master_req <= 1'($urandom);
            pulse(6'($urandom));
            a = ($urandom % 4 == 0) ? 8'($urandom) : 8'h04;
            wr(a, 4'($urandom), $urandom);
            chk("enables", {27'h0, exp_word[6], exp_word[8], exp_word[9], exp_word[2], exp_word[1]},
                {27'h0, en_par, en_serr, en_fast, en_bm, en_mem});
            chk("claims", {30'h0, mem_hit & exp_word[1], master_req & exp_word[2]},
                {30'h0, mem_claim, master_start});
            rd_chk(8'h04);
        end
        $display("test random done");
        repeat (8)
        begin
            coll_evt = 6'($urandom);
            fork
                wr(8'h04, 4'h8 | 4'($urandom), $urandom);
                begin
                    @(posedge core_clk);
                    evt <= coll_evt;
                    @(posedge core_clk);
                    evt <= 6'h0;
                end
            join
            exp_word = exp_word | {coll_evt[5:1], 2'h0, coll_evt[0], 24'h0};
            rd_chk(8'h04);
        end
        $display("test collision done");
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        exp_word = CSC_RESET;
        rd_chk(8'h04);
        chk("reset enables", 32'h0, {27'h0, en_par, en_serr, en_fast, en_bm, en_mem});
        $display("test second reset done");
        test_done;
    end
    initial
    begin
        repeat (3000) @(posedge core_clk);
        mismatches++;
        test_done;
    end
endmodule
